/* File: pwr_sched_regs.vh */
// Register map, field positions, reset values and timing constants of the power scheduler
`ifndef PWR_SCHED_REGS_VH
`define PWR_SCHED_REGS_VH

// Register byte offsets
`define A_CTRL 8'h00
`define A_GUARD 8'h04
`define A_CSW 8'h08
`define A_SLOTLEN 8'h0C
`define A_RSVTX 8'h10
`define A_RSVRX 8'h14
`define A_AVAIL 8'h18
`define A_CONT 8'h1C
`define A_HIB 8'h20
`define A_STAT 8'h24

// Control register bits
`define B_EN 0
`define B_MASTER 1
`define B_ADV 2
`define B_TXCONT 3

// Hibernation register fields
`define F_HIB_CNT 7:0
`define F_HIB_DUR 15:8
`define B_HIB_GO 31

// Status register fields
`define B_ST_AWAKE 0
`define B_ST_HIB 1
`define B_ST_ANN 2
`define B_ST_CCA 3
`define B_ST_UCA 4
`define F_ST_SLOT 11:8
`define F_ST_HCNT 23:16

// Reset values
`define CTRL_RST 4'h0
`define GUARD_RST 16'h0010
`define CSW_RST 16'h0020
`define SLOTLEN_RST 16'h0100
`define MASK_RST 16'h0000
`define HCNT_RST 8'h00

// Superframe shape: sixteen slots, slot 0 holds the beacon period
`define SLOT_W 4
`define SLOT_LAST 4'hF
`define SLOT_BCN 4'h0
`define SF_W 20

// Access delay: longest frame plus immediate ack plus short interframe space
`define CLK_PERIOD_NS 25
`define MAX_FRAME_NS 80000
`define IMM_ACK_NS 8000
`define SIFS_NS 2000
`define ACCESS_DELAY_NS (`MAX_FRAME_NS + `IMM_ACK_NS + `SIFS_NS)
`define ACCESS_DELAY_CYC (`ACCESS_DELAY_NS / `CLK_PERIOD_NS)
`define ACC_W 12

// Hibernation states
`define ST_ACTIVE 2'h0
`define ST_ANNOUNCE 2'h1
`define ST_HIBERNATE 2'h2

`endif

/* File: sf_timer.v */
// Superframe and slot position counter
`timescale 1ns/1ps
`include "pwr_sched_regs.vh"

module sf_timer
(
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Configuration
   input wire run_i,
   input wire [15:0] slot_len_i,
   // Position
   output reg [`SLOT_W-1:0] slot_idx_o,
   output reg [15:0] slot_cyc_o,
   output reg [`SF_W-1:0] sf_cyc_o,
   output reg sf_start_o,
   output reg slot_start_o
);

   wire slot_end;

   // Compare on cyc+1 so a zero slot length still advances every cycle
   assign slot_end = ({1'b0, slot_cyc_o} + 17'h00001) >= {1'b0, slot_len_i};

   ////////////////////////////////////////////////////////////////////////////
   // Slot and superframe counters, with one-cycle boundary pulses
   always @(posedge clk_i)
   begin
      if (rst_i || !run_i)
      begin
         slot_idx_o <= `SLOT_BCN;
         slot_cyc_o <= 16'h0000;
         sf_cyc_o <= 20'h00000;
         sf_start_o <= 1'b0;
         slot_start_o <= 1'b0;
      end
      else if (slot_end)
      begin
         slot_cyc_o <= 16'h0000;
         slot_start_o <= 1'b1;
         slot_idx_o <= slot_idx_o + 4'h1;
         if (slot_idx_o == `SLOT_LAST)
         begin
            sf_cyc_o <= 20'h00000;
            sf_start_o <= 1'b1;
         end
         else
         begin
            sf_cyc_o <= sf_cyc_o + 20'h00001;
            sf_start_o <= 1'b0;
         end
      end
      else
      begin
         slot_cyc_o <= slot_cyc_o + 16'h0001;
         sf_cyc_o <= sf_cyc_o + 20'h00001;
         sf_start_o <= 1'b0;
         slot_start_o <= 1'b0;
      end
   end

endmodule

/* File: pwr_sched.v */
// Power-state scheduler of a superframe MAC with its APB register file
`timescale 1ns/1ps
`include "pwr_sched_regs.vh"

// What this block does
// - Active mode talks in the superframe; hibernation sends and receives nothing.
// - Hibernation is announced in as many superframe beacons as its count before it begins.
// - A network master never hibernates and stays active.
// - Active device is either awake (tx and rx) or asleep (neither).
// - Waking with contention frame queued runs channel assessment before judging medium.
// - Access delay is longest frame plus immediate ack plus interframe space.
// - Awake guard time plus contention window before beacon period start.
// - Awake before own reserved block; may sleep once its sends succeeded.
// - Release a reserved block in the same cycle the radio sleeps inside it, advisory only.
// - Last frame sent in a reserved block carries more-frames cleared.
// - Pending contention sends are announced in beacon; sleep allowed when done.
// - Last contention frame to each recipient carries more-frames cleared.
// - Awake guard time before peer-announced reserved block; sleep when all received.
// - After unsolicited change announce stay awake until response is sent.
// - Advertised availability slots need wake guard time before each slot.
// - Without availability advertised stay awake in every contention slot.
// - After more-frames shows contention data all received, may sleep.
module pwr_sched
(
   // Clock and reset
   input wire MCLK_I,
   input wire RESET_I,
   // APB slave
   input wire PSEL_I,
   input wire PENABLE_I,
   input wire PWRITE_I,
   input wire [7:0] PADDR_I,
   input wire [31:0] PWDATA_I,
   output reg [31:0] PRDATA_O,
   output wire PREADY_O,
   output wire PSLVERR_O,
   // MAC events
   input wire RSV_TX_DONE_I,
   input wire RSV_RX_LAST_I,
   input wire CONT_TX_DONE_I,
   input wire CONT_RX_LAST_I,
   input wire UCA_RX_I,
   input wire UCR_TX_I,
   input wire HDR_RX_I,
   // Outgoing frame header
   input wire TX_FRAME_I,
   input wire TX_MORE_I,
   input wire TX_LAST_BLK_I,
   input wire TX_LAST_RCPT_I,
   output reg MORE_FRAMES_O,
   // Power state
   output reg AWAKE_O,
   output reg HIBERNATE_O,
   output reg HIB_ANNOUNCE_O,
   output reg TIM_ANNOUNCE_O,
   output reg AVAIL_ADV_O,
   output reg CCA_ACTIVE_O,
   output reg MEDIUM_JUDGE_O,
   output reg RELEASE_BLK_O
);

   // Mask lookup shared by the current and next slot checks
   function slot_hit;
      input [15:0] mask;
      input [`SLOT_W-1:0] idx;
      begin
         slot_hit = mask[idx];
      end
   endfunction

   reg [3:0] ctrl_q;
   reg [15:0] guard_q;
   reg [15:0] csw_q;
   reg [15:0] slot_len_q;
   reg [15:0] rsv_tx_q;
   reg [15:0] rsv_rx_q;
   reg [15:0] avail_q;
   reg [15:0] cont_q;
   reg [7:0] hib_cnt_cfg_q;
   reg [7:0] hib_dur_cfg_q;
   reg hib_go_q;
   reg [1:0] hstate_q;
   reg [7:0] hcnt_q;
   reg rsv_tx_done_q;
   reg rsv_rx_done_q;
   reg cont_tx_done_q;
   reg cont_rx_done_q;
   reg uca_pend_q;
   reg [`ACC_W-1:0] acc_cnt_q;
   reg need;
   reg [31:0] rd_d;
   reg addr_ok;
   wire wr_en;
   wire setup;
   wire run;
   wire [`SLOT_W-1:0] slot_idx;
   wire [`SLOT_W-1:0] slot_nxt;
   wire [15:0] slot_cyc;
   wire [`SF_W-1:0] sf_cyc;
   wire sf_start;
   wire slot_start;
   wire [`SF_W-1:0] sf_len;
   wire [`SF_W-1:0] sf_rem;
   wire [`SF_W-1:0] bcn_lead;
   wire [15:0] slot_rem;
   wire pre_next;
   wire hib;

   ////////////////////////////////////////////////////////////////////////////
   // Superframe position
   assign run = ctrl_q[`B_EN];

   sf_timer u_timer
   (
      .clk_i(MCLK_I),
      .rst_i(RESET_I),
      .run_i(run),
      .slot_len_i(slot_len_q),
      .slot_idx_o(slot_idx),
      .slot_cyc_o(slot_cyc),
      .sf_cyc_o(sf_cyc),
      .sf_start_o(sf_start),
      .slot_start_o(slot_start)
   );

   // Lead times; a guard longer than a slot only covers the adjacent slot
   assign slot_nxt = slot_idx + 4'h1;
   assign sf_len = {slot_len_q, 4'h0};
   assign sf_rem = sf_len - sf_cyc;
   // One spare cycle in each lead pays for the registered awake flag
   assign bcn_lead = {4'h0, guard_q} + {4'h0, csw_q} + 20'h00001;
   assign slot_rem = slot_len_q - slot_cyc;
   assign pre_next = {1'b0, slot_rem} <= ({1'b0, guard_q} + 17'h00001);
   assign hib = hstate_q == `ST_HIBERNATE;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode; zero wait states, error on unmapped offsets
   assign setup = PSEL_I && !PENABLE_I;
   assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && addr_ok;
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_ok;

   // Read mux, captured in the setup cycle so data sits in a flip-flop
   always @*
   begin
      addr_ok = 1'b1;
      rd_d = 32'h00000000;
      case (PADDR_I)
         `A_CTRL: rd_d[3:0] = ctrl_q;
         `A_GUARD: rd_d[15:0] = guard_q;
         `A_CSW: rd_d[15:0] = csw_q;
         `A_SLOTLEN: rd_d[15:0] = slot_len_q;
         `A_RSVTX: rd_d[15:0] = rsv_tx_q;
         `A_RSVRX: rd_d[15:0] = rsv_rx_q;
         `A_AVAIL: rd_d[15:0] = avail_q;
         `A_CONT: rd_d[15:0] = cont_q;
         `A_HIB:
         begin
            rd_d[`F_HIB_CNT] = hib_cnt_cfg_q;
            rd_d[`F_HIB_DUR] = hib_dur_cfg_q;
         end
         `A_STAT:
         begin
            rd_d[`B_ST_AWAKE] = AWAKE_O;
            rd_d[`B_ST_HIB] = HIBERNATE_O;
            rd_d[`B_ST_ANN] = HIB_ANNOUNCE_O;
            rd_d[`B_ST_CCA] = CCA_ACTIVE_O;
            rd_d[`B_ST_UCA] = uca_pend_q;
            rd_d[`F_ST_SLOT] = slot_idx;
            rd_d[`F_ST_HCNT] = hcnt_q;
         end
         default: addr_ok = 1'b0;
      endcase
   end

   // Register writes; the hibernation go bit is a one-cycle command
   always @(posedge MCLK_I)
   begin
      if (RESET_I)
      begin
         PRDATA_O <= 32'h00000000;
         ctrl_q <= `CTRL_RST;
         guard_q <= `GUARD_RST;
         csw_q <= `CSW_RST;
         slot_len_q <= `SLOTLEN_RST;
         rsv_tx_q <= `MASK_RST;
         rsv_rx_q <= `MASK_RST;
         avail_q <= `MASK_RST;
         cont_q <= `MASK_RST;
         hib_cnt_cfg_q <= `HCNT_RST;
         hib_dur_cfg_q <= `HCNT_RST;
         hib_go_q <= 1'b0;
      end
      else
      begin
         hib_go_q <= 1'b0;
         if (setup)
            PRDATA_O <= rd_d;
         if (wr_en)
         begin
            case (PADDR_I)
               `A_CTRL: ctrl_q <= PWDATA_I[3:0];
               `A_GUARD: guard_q <= PWDATA_I[15:0];
               `A_CSW: csw_q <= PWDATA_I[15:0];
               `A_SLOTLEN: slot_len_q <= PWDATA_I[15:0];
               `A_RSVTX: rsv_tx_q <= PWDATA_I[15:0];
               `A_RSVRX: rsv_rx_q <= PWDATA_I[15:0];
               `A_AVAIL: avail_q <= PWDATA_I[15:0];
               `A_CONT: cont_q <= PWDATA_I[15:0];
               `A_HIB:
               begin
                  hib_cnt_cfg_q <= PWDATA_I[`F_HIB_CNT];
                  hib_dur_cfg_q <= PWDATA_I[`F_HIB_DUR];
                  hib_go_q <= PWDATA_I[`B_HIB_GO];
               end
               default: hib_go_q <= 1'b0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Hibernation mode: announce, count down per superframe, hibernate
   always @(posedge MCLK_I)
   begin
      if (RESET_I || ctrl_q[`B_MASTER] || !run)
      begin
         hstate_q <= `ST_ACTIVE;
         hcnt_q <= `HCNT_RST;
      end
      else
      begin
         case (hstate_q)
            `ST_ACTIVE:
               if (hib_go_q && hib_dur_cfg_q != `HCNT_RST)
               begin
                  hstate_q <= `ST_ANNOUNCE;
                  hcnt_q <= hib_cnt_cfg_q;
               end
            `ST_ANNOUNCE:
               // Entry at the first superframe start with the count at zero, so a zero count puts the announcement in no later beacon
               if (sf_start)
               begin
                  if (hcnt_q == `HCNT_RST)
                  begin
                     hstate_q <= `ST_HIBERNATE;
                     hcnt_q <= hib_dur_cfg_q;
                  end
                  else
                     hcnt_q <= hcnt_q - 8'h01;
               end
            `ST_HIBERNATE:
               if (sf_start)
               begin
                  if (hcnt_q == 8'h01)
                     hstate_q <= `ST_ACTIVE;
                  hcnt_q <= hcnt_q - 8'h01;
               end
            default: hstate_q <= `ST_ACTIVE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-block and per-superframe progress flags; a set beats a boundary clear
   always @(posedge MCLK_I)
   begin
      if (RESET_I)
      begin
         rsv_tx_done_q <= 1'b0;
         rsv_rx_done_q <= 1'b0;
         cont_tx_done_q <= 1'b0;
         cont_rx_done_q <= 1'b0;
         uca_pend_q <= 1'b0;
      end
      else
      begin
         rsv_tx_done_q <= RSV_TX_DONE_I || (rsv_tx_done_q && !slot_start);
         rsv_rx_done_q <= RSV_RX_LAST_I || (rsv_rx_done_q && !slot_start);
         cont_tx_done_q <= CONT_TX_DONE_I || (cont_tx_done_q && !sf_start);
         cont_rx_done_q <= CONT_RX_LAST_I || (cont_rx_done_q && !sf_start);
         uca_pend_q <= UCA_RX_I || (uca_pend_q && !UCR_TX_I);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wake obligations; any one of them keeps the radio on
   always @*
   begin
      need = 1'b0;
      if (sf_rem <= bcn_lead || slot_idx == `SLOT_BCN)
         need = 1'b1;
      if (slot_hit(rsv_tx_q, slot_idx) && !rsv_tx_done_q)
         need = 1'b1;
      if (slot_hit(rsv_tx_q, slot_nxt) && pre_next)
         need = 1'b1;
      if (slot_hit(rsv_rx_q, slot_idx) && !rsv_rx_done_q)
         need = 1'b1;
      if (slot_hit(rsv_rx_q, slot_nxt) && pre_next)
         need = 1'b1;
      if (ctrl_q[`B_TXCONT] && !cont_tx_done_q)
         need = 1'b1;
      if (uca_pend_q || CCA_ACTIVE_O)
         need = 1'b1;
      if (!cont_rx_done_q)
      begin
         if (ctrl_q[`B_ADV])
         begin
            if (slot_hit(avail_q, slot_idx) || (slot_hit(avail_q, slot_nxt) && pre_next))
               need = 1'b1;
         end
         else if (slot_hit(cont_q, slot_idx))
            need = 1'b1;
      end
      // Disabled scheduler leaves the radio on; hibernation overrides all
      if (!run)
         need = 1'b1;
      if (hib)
         need = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power state and beacon indications
   always @(posedge MCLK_I)
   begin
      if (RESET_I)
      begin
         AWAKE_O <= 1'b1;
         HIBERNATE_O <= 1'b0;
         HIB_ANNOUNCE_O <= 1'b0;
         TIM_ANNOUNCE_O <= 1'b0;
         AVAIL_ADV_O <= 1'b0;
         RELEASE_BLK_O <= 1'b0;
      end
      else
      begin
         AWAKE_O <= need;
         HIBERNATE_O <= hib;
         HIB_ANNOUNCE_O <= hstate_q == `ST_ANNOUNCE;
         TIM_ANNOUNCE_O <= ctrl_q[`B_TXCONT] && !hib;
         AVAIL_ADV_O <= ctrl_q[`B_ADV] && !hib;
         // Advisory pulse: sleeping inside our own reserved slot
         RELEASE_BLK_O <= AWAKE_O && !need && !hib && slot_hit(rsv_tx_q, slot_idx);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel assessment after wake-up with a contention frame queued
   always @(posedge MCLK_I)
   begin
      if (RESET_I)
      begin
         CCA_ACTIVE_O <= 1'b0;
         MEDIUM_JUDGE_O <= 1'b0;
         acc_cnt_q <= {`ACC_W{1'b0}};
      end
      else
      begin
         MEDIUM_JUDGE_O <= 1'b0;
         if (!AWAKE_O && need && ctrl_q[`B_TXCONT] && !cont_tx_done_q)
         begin
            CCA_ACTIVE_O <= 1'b1;
            acc_cnt_q <= {`ACC_W{1'b0}};
         end
         else if (CCA_ACTIVE_O)
         begin
            // Header seen or full access delay waited, whichever first
            if (HDR_RX_I || acc_cnt_q == `ACCESS_DELAY_CYC - 1)
            begin
               CCA_ACTIVE_O <= 1'b0;
               MEDIUM_JUDGE_O <= 1'b1;
            end
            // Hibernation silences the radio, so the assessment is dropped
            else if (hib)
               CCA_ACTIVE_O <= 1'b0;
            else
               acc_cnt_q <= acc_cnt_q + 12'h001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // More-frames bit of the outgoing frame header
   always @(posedge MCLK_I)
   begin
      if (RESET_I)
         MORE_FRAMES_O <= 1'b0;
      else if (TX_FRAME_I)
         MORE_FRAMES_O <= TX_MORE_I && !TX_LAST_BLK_I && !TX_LAST_RCPT_I;
   end

endmodule

/* File: pwr_sched_sva.sv */
// Port-level checks of the power scheduler
`timescale 1ns/1ps
module pwr_sched_sva
(
   // Clock, reset and bus
   input wire MCLK_I,
   input wire RESET_I,
   input wire PSEL_I,
   input wire PENABLE_I,
   input wire PWRITE_I,
   input wire [7:0] PADDR_I,
   input wire [31:0] PRDATA_O,
   input wire PREADY_O,
   input wire PSLVERR_O,
   // Frame and power state
   input wire HDR_RX_I,
   input wire TX_FRAME_I,
   input wire TX_MORE_I,
   input wire TX_LAST_BLK_I,
   input wire TX_LAST_RCPT_I,
   input wire MORE_FRAMES_O,
   input wire AWAKE_O,
   input wire HIBERNATE_O,
   input wire HIB_ANNOUNCE_O,
   input wire TIM_ANNOUNCE_O,
   input wire CCA_ACTIVE_O,
   input wire MEDIUM_JUDGE_O
);
   ////////////////////////////////////////////////////////////////////////////////
   // Address decode and assessment run length
   wire acc = PSEL_I && PENABLE_I;
   wire bad = (PADDR_I > 8'h24) || (PADDR_I[1:0] != 2'h0);
   reg [12:0] cca_cnt_q;
   always @(posedge MCLK_I)
   begin
      if (RESET_I || !CCA_ACTIVE_O)
         cca_cnt_q <= 13'h0;
      else
         cca_cnt_q <= cca_cnt_q + 13'h1;
   end
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (RESET_I);
   ////////////////////////////////////////////////////////////////////////////////
   // Bus, mode and frame checks
   a_zero_wait:
   assert property (acc |-> PREADY_O) else $error("pready low");
   a_err_decode:
   assert property (acc |-> PSLVERR_O == bad) else $error("slave error decode");
   a_bad_read_zero:
   assert property (acc && !PWRITE_I && bad |-> PRDATA_O == 32'h0) else $error("unmapped data");
   a_hib_silent:
   assert property (HIBERNATE_O |-> !AWAKE_O && !TIM_ANNOUNCE_O) else $error("hib radio on");
   a_hib_announced:
   assert property ($rose(HIBERNATE_O) |-> $past(HIB_ANNOUNCE_O)) else $error("no announce");
   a_cca_awake:
   assert property (CCA_ACTIVE_O |-> AWAKE_O) else $error("cca while asleep");
   a_cca_hdr_end:
   assert property (CCA_ACTIVE_O && HDR_RX_I |=> !CCA_ACTIVE_O && MEDIUM_JUDGE_O
      ##1 !MEDIUM_JUDGE_O) else $error("cca end on header");
   a_judge_cause:
   assert property (MEDIUM_JUDGE_O |-> $past(CCA_ACTIVE_O) && !CCA_ACTIVE_O)
      else $error("judge without cca");
   a_cca_bound:
   assert property (cca_cnt_q <= 13'hE10) else $error("cca too long");
   a_more_frames:
   assert property (TX_FRAME_I |=> MORE_FRAMES_O ==
      $past(TX_MORE_I && !TX_LAST_BLK_I && !TX_LAST_RCPT_I)) else $error("more frames");
endmodule

/* File: peer_mac.sv */
// Peer device that may answer a channel assessment with a frame header
`timescale 1ns/1ps
module peer_mac
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bench control
   input wire logic silent_i,
   input wire logic [7:0] delay_i,
   // Medium
   input wire logic cca_i,
   output logic hdr_o = 1'b0
);
   logic [7:0] cnt_q = 8'h00;
   // Header after the set delay; silent peer lets the full delay run out
   always @(posedge clk_i)
   begin
      if (rst_i || !cca_i)
         cnt_q <= 8'h00;
      else if (cnt_q != 8'hFF)
         cnt_q <= cnt_q + 8'h01;
      hdr_o <= !rst_i && cca_i && !silent_i && cnt_q == delay_i;
   end
endmodule

/* File: tb.sv */
// Self-checking bench of the power scheduler
`timescale 1ns/1ps
`include "pwr_sched_regs.vh"
module tb;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
   logic [7:0] paddr = 8'h00, dly = 8'h10;
   logic [31:0] pwdata = 32'h0, rd, v;
   logic unsolicited_change_announce = 1'b0, unsolicited_change_response = 1'b0, ctd = 1'b0, crl = 1'b0, silent = 1'b1;
   logic rtd = 1'b0, rrl = 1'b0;
   wire rel;
   logic txf = 1'b0, txm = 1'b0, txb = 1'b0, txr = 1'b0;
   wire [31:0] prdata;
   wire pready, slverr, hdr, more, awake, hib, hann, tim, adv, cca, judge;
   logic [7:0] ra [7];
   logic [15:0] rv [7];
   int errors = 0, checks = 0, n;
   // 40 MHz clock
   always #12.5 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////////
   // Design and far side
   pwr_sched uut (.MCLK_I(mclk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(slverr), .RSV_TX_DONE_I(rtd), .RSV_RX_LAST_I(rrl),
      .CONT_TX_DONE_I(ctd), .CONT_RX_LAST_I(crl), .UCA_RX_I(unsolicited_change_announce), .UCR_TX_I(unsolicited_change_response),
      .HDR_RX_I(hdr), .TX_FRAME_I(txf), .TX_MORE_I(txm), .TX_LAST_BLK_I(txb),
      .TX_LAST_RCPT_I(txr), .MORE_FRAMES_O(more), .AWAKE_O(awake), .HIBERNATE_O(hib),
      .HIB_ANNOUNCE_O(hann), .TIM_ANNOUNCE_O(tim), .AVAIL_ADV_O(adv), .CCA_ACTIVE_O(cca),
      .MEDIUM_JUDGE_O(judge), .RELEASE_BLK_O(rel));
   peer_mac peer (.clk_i(mclk), .rst_i(rst), .silent_i(silent), .delay_i(dly), .cca_i(cca),
      .hdr_o(hdr));
   ////////////////////////////////////////////////////////////////////////////////
   // Compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // Expected more-frames bit from more, last-in-block, last-to-recipient
   function logic exp_more(input logic [2:0] s);
      return s[2] & ~s[1] & ~s[0];
   endfunction
   // One APB transfer, held until pready is seen high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      pen <= 1'b1;
      do
         @(posedge mclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = slverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // Wait for a fall of awake, which starts a long quiet stretch of the superframe
   task sleep_edge;
      for (n = 0; n < 3000 && awake !== 1'b1; n++) @(posedge mclk);
      for (n = 0; n < 3000 && awake !== 1'b0; n++) @(posedge mclk);
   endtask
   task end_sim;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog, well beyond the expected run of some 7500 cycles
   initial
   begin
      #(25 * 40000);
      errors++;
      $display("mismatch at %0t: watchdog", $time);
      end_sim;
   end
   // Main sequence
   initial
   begin
      ra = '{`A_GUARD, `A_CSW, `A_SLOTLEN, `A_RSVTX, `A_RSVRX, `A_AVAIL, `A_CONT};
      rv = '{`GUARD_RST, `CSW_RST, `SLOTLEN_RST, `MASK_RST, `MASK_RST, `MASK_RST, `MASK_RST};
      v = $urandom(32'hAE04);
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      chk(awake, 1, "awake at reset");
      apb(0, `A_STAT, 0);
      chk(rd, 32'h1, "status reset");
      foreach (ra[i])
      begin
         apb(0, ra[i], 0);
         chk(rd, {16'h0, rv[i]}, "reset value");
         v = $urandom;
         apb(1, ra[i], v);
         apb(0, ra[i], 0);
         chk(rd, {16'h0, v[15:0]}, "read back");
         apb(1, ra[i], i < 2 ? 4 : i == 2 ? 32'h40 : i == 6 ? 32'h4 : 0);
      end
      foreach (rv[i])
      begin
         v = {$urandom, 2'h1} + (i < 3 ? 32'h0 : 32'h28);
         apb(1, i < 3 ? v[7:0] : 8'h28 + v[7:0] % 8'hD0, $urandom);
         chk(err, 1, "unmapped write");
         apb(0, paddr, 0);
         chk(rd, 0, "unmapped read");
      end
      $display("test registers done");
      for (int k = 0; k < 8; k++)
      begin
         @(posedge mclk);
         txf <= 1'b1;
         {txm, txb, txr} <= k[2:0];
         @(posedge mclk);
         txf <= 1'b0;
         @(posedge mclk);
         chk(more, exp_more(k[2:0]), "more frames");
      end
      $display("test more frames done");
      // Contention slot 2 listening, then released by the last-data pulse
      apb(1, `A_CTRL, 1);
      sleep_edge;
      repeat (70) @(posedge mclk);
      chk(awake, 1, "contention slot");
      crl <= 1'b1;
      @(posedge mclk);
      crl <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(awake, 0, "all received");
      apb(1, `A_CONT, 0);
      // Announce received keeps the radio up until the response
      sleep_edge;
      unsolicited_change_announce <= 1'b1;
      @(posedge mclk);
      unsolicited_change_announce <= 1'b0;
      repeat (40) @(posedge mclk);
      chk(awake, 1, "response pending");
      unsolicited_change_response <= 1'b1;
      @(posedge mclk);
      unsolicited_change_response <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(awake, 0, "response sent");
      // Own, peer and availability slots 3, 5, 7: woken ahead, asleep once done
      apb(1, `A_CTRL, 5);
      for (int k = 0; k < 3; k++)
      begin
         repeat (k ? 38 : 0) @(posedge mclk);
         apb(1, k == 0 ? `A_RSVTX : k == 1 ? `A_RSVRX : `A_AVAIL, 32'h8 << (2 * k));
         repeat (64) @(posedge mclk);
         chk(awake, 0, "asleep ahead of slot");
         repeat (10) @(posedge mclk);
         chk(awake, 1, "awake before slot");
         repeat (10) @(posedge mclk);
         chk(awake, 1, "awake in slot");
         {crl, rrl, rtd} <= 3'h1 << k;
         @(posedge mclk);
         {crl, rrl, rtd} <= 3'h0;
         repeat (2) @(posedge mclk);
         chk(awake, 0, "slot work done");
         chk(rel, k == 0, "release advice");
      end
      apb(1, `A_RSVTX, 0);
      apb(1, `A_RSVRX, 0);
      $display("test sleep duties done");
      // Silent peer: assessment runs the whole access delay; then a prompt peer
      for (int k = 0; k < 2; k++)
      begin
         apb(1, `A_CTRL, 1);
         sleep_edge;
         silent <= k == 0;
         dly <= 8'h08 + 8'($urandom % 32);
         apb(1, `A_CTRL, 9);
         for (n = 0; n < 10 && cca !== 1'b1; n++) @(posedge mclk);
         chk(awake, 1, "awake in cca");
         chk(tim, 1, "traffic element");
         for (n = 0; n < 5000 && judge !== 1'b1; n++) @(posedge mclk);
         chk(cca, 0, "cca over at judge");
         chk(k == 0 ? n >= 3600 && n <= 3602 : n == dly + 2, 1, "cca length");
      end
      ctd <= 1'b1;
      @(posedge mclk);
      ctd <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(awake, 0, "contention sends done");
      $display("test channel assessment done");
      // Hibernation: announce, enter, master forces out and blocks it
      apb(1, `A_CTRL, 1);
      apb(1, `A_HIB, 32'h8000_0201);
      repeat (3) @(posedge mclk);
      chk(hann, 1, "announce");
      for (n = 0; n < 5000 && hib !== 1'b1; n++) @(posedge mclk);
      apb(0, `A_STAT, 0);
      chk(rd[1:0], 2'h2, "hibernating asleep");
      apb(1, `A_CTRL, 3);
      repeat (3) @(posedge mclk);
      chk(hib, 0, "master active");
      apb(1, `A_HIB, 32'h8000_0201);
      repeat (3) @(posedge mclk);
      chk(hann, 0, "master no announce");
      apb(1, `A_CTRL, 5);
      repeat (3) @(posedge mclk);
      chk(adv, 1, "availability element");
      $display("test hibernation done");
      end_sim;
   end
endmodule
bind pwr_sched pwr_sched_sva chk (.MCLK_I(MCLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I),
   .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
   .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .HDR_RX_I(HDR_RX_I), .TX_FRAME_I(TX_FRAME_I),
   .TX_MORE_I(TX_MORE_I), .TX_LAST_BLK_I(TX_LAST_BLK_I), .TX_LAST_RCPT_I(TX_LAST_RCPT_I),
   .MORE_FRAMES_O(MORE_FRAMES_O), .AWAKE_O(AWAKE_O), .HIBERNATE_O(HIBERNATE_O),
   .HIB_ANNOUNCE_O(HIB_ANNOUNCE_O), .TIM_ANNOUNCE_O(TIM_ANNOUNCE_O),
   .CCA_ACTIVE_O(CCA_ACTIVE_O), .MEDIUM_JUDGE_O(MEDIUM_JUDGE_O));
